// [dv/scan_master_model.sv]
// Test bus master model driving the primary test port and protocol pulses
module scan_master_model
	import scan_link_pkg::*;
(
	// Primary test port
	output logic              tck_o,
	output logic              trst_n_o,
	output logic              tms_o,
	output logic              tdi_o,
	// Received protocol fields
	output logic              valid_o,
	output logic [ADDR_W-1:0] addr_o,
	output logic [POS_W-1:0]  pos_o,
	output logic [CFG_W-1:0]  cfg_o
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		tck_o = 1'b1;
		trst_n_o = 1'b0;
		tms_o = 1'b1;
		tdi_o = 1'b0;
		valid_o = 1'b0;
		addr_o = '0;
		pos_o = '0;
		cfg_o = '0;
	end
	// One link cycle; clock rests high between frames
	task automatic tick(input logic ms, input logic v);
		tms_o <= ms;
		tdi_o <= ~tdi_o;
		valid_o <= v;
		#80 tck_o <= 1'b0;
		#79 tck_o <= 1'b1;
		#1;
	endtask : tick
	// Walk the monitor, first step in bit 0
	task automatic walk(input logic [7:0] path, input int n);
		for (int i = 0; i < n; i++) begin
			tick(path[i], 1'b0);
		end
	endtask : walk
	// One protocol pulse, then idle cycles; fields scrambled once released
	task automatic send(input logic [ADDR_W-1:0] a, input logic [POS_W-1:0] p,
			input logic [CFG_W-1:0] c, input int idle);
		addr_o <= a;
		pos_o <= p;
		cfg_o <= c;
		tick(1'b0, 1'b1);
		addr_o <= ~a;
		pos_o <= ~p;
		cfg_o <= ~c;
		walk(8'h00, idle);
	endtask : send
	// Asynchronous link reset, then settle in Test-Logic-Reset
	task automatic reset_link();
		trst_n_o <= 1'b0;
		walk(8'hff, 2);
		trst_n_o <= 1'b1;
		walk(8'hff, 4);
	endtask : reset_link
endmodule : scan_master_model

// [dv/testbench.sv]
// Self-checking bench for the scan linker connect control
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	import scan_link_pkg::*;
	typedef struct {logic [33:0] v; logic [33:0] m;} exp_t;
	logic        clk, srst, awv, awr, wv, wr, bv, bready, arv, arr, rv, rready, pdo, pdo_oe;
	logic        tck, trst_n, tms, tdi, pv, oe_prev;
	logic [31:0] awaddr, wdata, araddr, rdata, seed, r;
	logic [1:0]  bresp, rresp;
	logic [9:0]  pa, board;
	logic [2:0]  pp, pc, slot, sdi, so, so_oe, so_ms, ms, c;
	logic [15:0] bits;
	exp_t        exp_q[$];
	logic [15:0] ack_q[$];
	int          fail_count, total_checks;
	scan_link_connect_control i_dut (.SYS_CLK_I(clk), .SRST_I(srst),
		.S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr),
		.S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr),
		.S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bready),
		.S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
		.S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rv),
		.S_AXI_RREADY_I(rready), .PRIMARY_TEST_CLOCK_I(tck), .PRIMARY_TEST_RESET_N_I(trst_n),
		.PRIMARY_MODE_SELECT_I(tms), .PRIMARY_TEST_DATA_IN_I(tdi),
		.PRIMARY_TEST_DATA_OUT_O(pdo), .PRIMARY_TEST_DATA_OUT_OE_O(pdo_oe),
		.PROTO_VALID_I(pv), .PROTO_ADDR_I(pa), .PROTO_POS_I(pp), .PROTO_CFG_I(pc),
		.BOARD_ADDRESS_I(board), .SLOT_POSITION_I(slot), .SECONDARY_TEST_DATA_IN_I(sdi),
		.SECONDARY_TEST_DATA_OUT_O(so), .SECONDARY_TEST_DATA_OUT_OE_O(so_oe),
		.SECONDARY_MODE_SELECT_O(so_ms));
	scan_master_model i_master (.tck_o(tck), .trst_n_o(trst_n), .tms_o(tms), .tdi_o(tdi),
		.valid_o(pv), .addr_o(pa), .pos_o(pp), .cfg_o(pc));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic check(input logic [33:0] seen, input logic [33:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic results();
		$display("Checks %0d, mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : results
	task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		exp_q.push_back('{{er, 32'h0}, 34'h3_0000_0000});
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 100 && !(bv === 1'b1 && bready); n++) begin
			@(posedge clk);
			if (awr === 1'b1) awv <= 1'b0;
			if (wr === 1'b1) wv <= 1'b0;
		end
		bready <= 1'b0;
		if (n == 100) begin
			fail_count++;
			results();
		end
	endtask : axi_wr
	task automatic axi_rd(input logic [31:0] a, input logic [33:0] ev, input logic [33:0] em);
		int n;
		exp_q.push_back('{ev, em});
		@(posedge clk);
		araddr <= a;
		arv <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 100 && !(rv === 1'b1 && rready); n++) begin
			@(posedge clk);
			if (arr === 1'b1) arv <= 1'b0;
		end
		rready <= 1'b0;
		if (n == 100) begin
			fail_count++;
			results();
		end
	endtask : axi_rd
	// Status readback; configuration compared only in ON
	task automatic st(input logic [4:0] con, input logic [15:0] tap, input logic [2:0] cf);
		axi_rd(STATUS_OFFSET, {RESP_OKAY, 8'h0, cf, con, tap},
			con == CON_ON ? 34'h3_ffff_ffff : 34'h3_001f_ffff);
	endtask : st
	task automatic match();
		c = 3'(rnd());
		ack_q.push_back({c, slot, board});
		i_master.send(board, slot, c, 22);
	endtask : match
	// Bus responses compared against the oldest note
	always @(posedge clk) begin
		if ((rv === 1'b1 && rready === 1'b1) || (bv === 1'b1 && bready === 1'b1)) begin
			if (exp_q.size() == 0) exp_q.push_back('{'x, '1});
			check((bv === 1'b1 ? {bresp, 32'h0} : {rresp, rdata}) & exp_q[0].m,
				exp_q[0].v & exp_q[0].m);
			void'(exp_q.pop_front());
		end
	end
	// Acknowledge collector on the primary data output
	initial forever begin
		@(posedge tck);
		#2;
		if (pdo_oe === 1'b1 && oe_prev !== 1'b1) begin
			bits[0] = pdo;
			for (int i = 1; i < ACK_W; i++) begin
				@(posedge tck);
				#2;
				bits[i] = pdo;
			end
			check({18'h0, bits}, ack_q.size() ? {18'h0, ack_q.pop_front()} : 'x);
		end
		oe_prev = pdo_oe;
	end
	always @(posedge tck) sdi <= 3'(rnd());
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		{srst, awv, wv, bready, arv, rready} = 6'h20;
		{awaddr, wdata, araddr, sdi} = '0;
		seed = 32'h42afd374;
		r = rnd();
		board = {2'b01, r[7:0]};
		slot = r[10:8];
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		i_master.reset_link();
		st(CON_RESET, TAP_TLR, 3'h0);
		axi_rd(CTRL_OFFSET, {RESP_OKAY, 32'h1}, 34'h3_ffff_ffff);
		axi_rd(32'h8, {RESP_SLVERR, 32'h0}, 34'h3_ffff_ffff);
		axi_wr(STATUS_OFFSET, 32'h0, RESP_SLVERR);
		i_master.walk(8'h00, 1);
		match();
		st(CON_ON, TAP_RTI, c);
		check({30'h0, so_oe, pdo_oe}, {30'h0, c, 1'b1});
		ms = so_ms;
		i_master.send(DROP_ALL_ADDRESS, 3'h0, 3'h0, 4);
		check({31'h0, so_ms}, {31'h0, ms});
		check({30'h0, so_oe, pdo_oe}, 34'h0);
		st(CON_OFF, TAP_RTI, 3'h0);
		for (int k = 0; k < 2; k++) begin
			match();
			i_master.send(board ^ (k ? 10'h0 : 10'h0f0), slot ^ k[2:0], 3'h0, 4);
			check({30'h0, so_oe, pdo_oe}, 34'h0);
			st(CON_OFF, TAP_RTI, 3'h0);
		end
		i_master.walk(8'h01, 3);
		i_master.send(RESET_ALL_ADDRESS, 3'h0, 3'h0, 4);
		st(CON_OFF, TAP_SHDR, 3'h0);
		i_master.walk(8'h03, 3);
		i_master.send(RESET_ALL_ADDRESS, 3'h0, 3'h0, 4);
		check({28'h0, so_ms, so_oe}, {28'h0, 3'h7, 3'h0});
		st(CON_RESET, TAP_RTI, 3'h0);
		i_master.send(SYNC_BROADCAST_ADDRESS, 3'h0, 3'h0, 4);
		st(CON_OFF, TAP_RTI, 3'h0);
		i_master.walk(8'h05, 4);
		i_master.send(SYNC_BROADCAST_ADDRESS, 3'h0, 3'h0, 4);
		check({27'h0, so, so_oe, pdo_oe}, {27'h0, {3{tdi}}, 3'h7, 1'b0});
		st(CON_MULTI, TAP_PAUDR, 3'h0);
		i_master.walk(8'h01, 2);
		i_master.walk(8'h2f, 7);
		match();
		st(CON_ON, TAP_PAUIR, c);
		axi_wr(CTRL_OFFSET, 32'h0, RESP_OKAY);
		i_master.walk(8'h00, 3);
		i_master.send(DROP_ALL_ADDRESS, 3'h0, 3'h0, 4);
		st(CON_ON, TAP_PAUIR, c);
		axi_wr(CTRL_OFFSET, 32'h1, RESP_OKAY);
		results();
	end
endmodule : testbench

// [rtl/scan_link_connect_control.sv]
// Connect control of the scan linker with an AXI4-Lite status and control slave
// Summary of operation
// - Ignore protocols in shift, exit, update, capture and select states
// - Pause-DR and Pause-IR accept protocols and recognize sync broadcast address
// - Connect status comes from comparing address with board and global addresses
// - All-zeros address: RESET status, outputs tristated, mode selects high, no ack
// - Drop-all address: OFF status, tristate, mode selects held, no ack
// - All-ones address in Pause-DR or Pause-IR gives test synchronization result and MULTICAST status
// - Mismatched address or position: OFF status, tristate, levels held, no ack
// - Matching address and position: send acknowledge on primary data output
// - ON status with received configuration only after the full acknowledge
// - In ON, route primary signals to configured secondary ports
// - Any accepted protocol (stable state, receive enabled, no ack running) selecting another device drops the connection
// - State monitor follows sampled mode select on each rising primary clock edge
// - Monitor starts in Test-Logic-Reset, forced there asynchronously by reset
// - Test-Logic-Reset and Run-Test/Idle accept protocols, no sync broadcast
// - Sync broadcast: MULTICAST, primary in and mode select to ports, no ack
//
// Local design decisions: the address map and the AXI4-Lite register port.
module scan_link_connect_control
	import scan_link_pkg::*;
(
	// System clock and reset
	input  wire logic                SYS_CLK_I,
	input  wire logic                SRST_I,
	// AXI4-Lite slave
	input  wire logic [31:0]         S_AXI_AWADDR_I,
	input  wire logic                S_AXI_AWVALID_I,
	output logic                     S_AXI_AWREADY_O,
	input  wire logic [31:0]         S_AXI_WDATA_I,
	input  wire logic [3:0]          S_AXI_WSTRB_I,
	input  wire logic                S_AXI_WVALID_I,
	output logic                     S_AXI_WREADY_O,
	output logic [1:0]               S_AXI_BRESP_O,
	output logic                     S_AXI_BVALID_O,
	input  wire logic                S_AXI_BREADY_I,
	input  wire logic [31:0]         S_AXI_ARADDR_I,
	input  wire logic                S_AXI_ARVALID_I,
	output logic                     S_AXI_ARREADY_O,
	output logic [31:0]              S_AXI_RDATA_O,
	output logic [1:0]               S_AXI_RRESP_O,
	output logic                     S_AXI_RVALID_O,
	input  wire logic                S_AXI_RREADY_I,
	// Primary test port
	input  wire logic                PRIMARY_TEST_CLOCK_I,
	input  wire logic                PRIMARY_TEST_RESET_N_I,
	input  wire logic                PRIMARY_MODE_SELECT_I,
	input  wire logic                PRIMARY_TEST_DATA_IN_I,
	output logic                     PRIMARY_TEST_DATA_OUT_O,
	output logic                     PRIMARY_TEST_DATA_OUT_OE_O,
	// Received protocol from the receive block
	input  wire logic                PROTO_VALID_I,
	input  wire logic [ADDR_W-1:0]   PROTO_ADDR_I,
	input  wire logic [POS_W-1:0]    PROTO_POS_I,
	input  wire logic [CFG_W-1:0]    PROTO_CFG_I,
	// Board straps
	input  wire logic [ADDR_W-1:0]   BOARD_ADDRESS_I,
	input  wire logic [POS_W-1:0]    SLOT_POSITION_I,
	// Secondary test ports
	input  wire logic [NPORT-1:0]    SECONDARY_TEST_DATA_IN_I,
	output logic [NPORT-1:0]         SECONDARY_TEST_DATA_OUT_O,
	output logic [NPORT-1:0]         SECONDARY_TEST_DATA_OUT_OE_O,
	output logic [NPORT-1:0]         SECONDARY_MODE_SELECT_O
);

	// Link domain state
	tap_state_t          tap_q, tap_d;
	con_state_t          con_q, con_d;
	logic [CFG_W-1:0]    cfg_q;
	logic [ACK_W-1:0]    ack_sr_q;
	logic [4:0]          ack_cnt_q;
	logic [ADDR_W-1:0]   addr_s1_q, addr_s2_q;
	logic [POS_W-1:0]    pos_s1_q, pos_s2_q;
	logic                rx_en_s1_q, rx_en_s2_q;
	logic                ack_s1_q, ack_s2_q, req_q;
	logic [STAT_W-1:0]   stat_hold_q;
	logic [NPORT-1:0]    sdo_d, sdo_oe_d, sms_d;
	logic                pdo_d, pdo_oe_d;

	// System domain state
	logic                rx_en_q;
	logic                req_s1_q, req_s2_q, ack_q;
	logic [STAT_W-1:0]   stat_sys_q;
	logic [31:0]         awaddr_q, wdata_q;
	logic [3:0]          wstrb_q;

	// Link domain clock and reset for the checks
	default clocking link_cb @(posedge PRIMARY_TEST_CLOCK_I);
	endclocking
	default disable iff (!PRIMARY_TEST_RESET_N_I);

	// Protocol decode
	wire pause_st  = (tap_q == TAP_PAUDR) || (tap_q == TAP_PAUIR);
	wire stable_st = (tap_q == TAP_TLR) || (tap_q == TAP_RTI) || pause_st;
	wire accept    = PROTO_VALID_I && stable_st && rx_en_s2_q && (con_q != CON_ACK);
	wire is_rsa    = (PROTO_ADDR_I == RESET_ALL_ADDRESS);
	wire is_dsa    = (PROTO_ADDR_I == DROP_ALL_ADDRESS);
	wire is_tsa    = (PROTO_ADDR_I == SYNC_BROADCAST_ADDRESS);
	wire is_match  = (PROTO_ADDR_I == addr_s2_q) && (PROTO_POS_I == pos_s2_q);
	wire ack_done  = (con_q == CON_ACK) && (ack_cnt_q == ACK_LAST);
	wire [STAT_W-1:0] stat_live = {cfg_q, con_q, tap_q};

	// State monitor next state
	always_comb begin
		tap_d = tap_q;
		case (tap_q)
			TAP_TLR:   tap_d = PRIMARY_MODE_SELECT_I ? TAP_TLR   : TAP_RTI;
			TAP_RTI:   tap_d = PRIMARY_MODE_SELECT_I ? TAP_SELDR : TAP_RTI;
			TAP_SELDR: tap_d = PRIMARY_MODE_SELECT_I ? TAP_SELIR : TAP_CAPDR;
			TAP_CAPDR: tap_d = PRIMARY_MODE_SELECT_I ? TAP_EX1DR : TAP_SHDR;
			TAP_SHDR:  tap_d = PRIMARY_MODE_SELECT_I ? TAP_EX1DR : TAP_SHDR;
			TAP_EX1DR: tap_d = PRIMARY_MODE_SELECT_I ? TAP_UPDR  : TAP_PAUDR;
			TAP_PAUDR: tap_d = PRIMARY_MODE_SELECT_I ? TAP_EX2DR : TAP_PAUDR;
			TAP_EX2DR: tap_d = PRIMARY_MODE_SELECT_I ? TAP_UPDR  : TAP_SHDR;
			TAP_UPDR:  tap_d = PRIMARY_MODE_SELECT_I ? TAP_SELDR : TAP_RTI;
			TAP_SELIR: tap_d = PRIMARY_MODE_SELECT_I ? TAP_TLR   : TAP_CAPIR;
			TAP_CAPIR: tap_d = PRIMARY_MODE_SELECT_I ? TAP_EX1IR : TAP_SHIR;
			TAP_SHIR:  tap_d = PRIMARY_MODE_SELECT_I ? TAP_EX1IR : TAP_SHIR;
			TAP_EX1IR: tap_d = PRIMARY_MODE_SELECT_I ? TAP_UPIR  : TAP_PAUIR;
			TAP_PAUIR: tap_d = PRIMARY_MODE_SELECT_I ? TAP_EX2IR : TAP_PAUIR;
			TAP_EX2IR: tap_d = PRIMARY_MODE_SELECT_I ? TAP_UPIR  : TAP_SHIR;
			TAP_UPIR:  tap_d = PRIMARY_MODE_SELECT_I ? TAP_SELDR : TAP_RTI;
			default:   tap_d = TAP_TLR;
		endcase
	end

	// Connect status next value, global addresses first
	always_comb begin
		con_d = con_q;
		if (accept) begin
			if (is_rsa) begin
				con_d = CON_RESET;
			end else if (is_tsa && pause_st) begin
				con_d = CON_MULTI;
			end else if (is_tsa || is_dsa) begin
				con_d = CON_OFF;
			end else if (is_match) begin
				con_d = CON_ACK;
			end else begin
				con_d = CON_OFF;
			end
		end else if (ack_done) begin
			con_d = CON_ON;
		end
	end

	// Port routing from the current status
	always_comb begin : route
		logic ch;
		ch       = PRIMARY_TEST_DATA_IN_I;
		sdo_d    = '0;
		sdo_oe_d = '0;
		sms_d    = SECONDARY_MODE_SELECT_O;
		pdo_d    = 1'b0;
		pdo_oe_d = 1'b0;
		case (con_q)
			CON_ON: begin
				for (int i = 0; i < NPORT; i++) begin
					if (cfg_q[i]) begin
						sdo_d[i]    = ch;
						sdo_oe_d[i] = 1'b1;
						sms_d[i]    = PRIMARY_MODE_SELECT_I;
						ch          = SECONDARY_TEST_DATA_IN_I[i];
					end
				end
				pdo_d    = ch;
				pdo_oe_d = 1'b1;
			end
			CON_MULTI: begin
				sdo_d    = {NPORT{PRIMARY_TEST_DATA_IN_I}};
				sdo_oe_d = '1;
				sms_d    = {NPORT{PRIMARY_MODE_SELECT_I}};
			end
			CON_ACK: begin
				pdo_d    = ack_sr_q[0];
				pdo_oe_d = 1'b1;
			end
			CON_RESET: sms_d = '1;
			default: sms_d = SECONDARY_MODE_SELECT_O;
		endcase
	end

	// Link domain registers
	always_ff @(posedge PRIMARY_TEST_CLOCK_I or negedge PRIMARY_TEST_RESET_N_I) begin
		if (!PRIMARY_TEST_RESET_N_I) begin
			tap_q       <= TAP_TLR;
			con_q       <= CON_RESET;
			cfg_q       <= '0;
			ack_sr_q    <= '0;
			ack_cnt_q   <= '0;
			addr_s1_q   <= '0;
			addr_s2_q   <= '0;
			pos_s1_q    <= '0;
			pos_s2_q    <= '0;
			rx_en_s1_q  <= 1'b0;
			rx_en_s2_q  <= 1'b0;
			ack_s1_q    <= 1'b0;
			ack_s2_q    <= 1'b0;
			req_q       <= 1'b0;
			stat_hold_q <= '0;
			PRIMARY_TEST_DATA_OUT_O      <= 1'b0;
			PRIMARY_TEST_DATA_OUT_OE_O   <= 1'b0;
			SECONDARY_TEST_DATA_OUT_O    <= '0;
			SECONDARY_TEST_DATA_OUT_OE_O <= '0;
			SECONDARY_MODE_SELECT_O      <= '1;
		end else begin
			tap_q      <= tap_d;
			con_q      <= con_d;
			addr_s1_q  <= BOARD_ADDRESS_I;
			addr_s2_q  <= addr_s1_q;
			pos_s1_q   <= SLOT_POSITION_I;
			pos_s2_q   <= pos_s1_q;
			rx_en_s1_q <= rx_en_q;
			rx_en_s2_q <= rx_en_s1_q;
			ack_s1_q   <= ack_q;
			ack_s2_q   <= ack_s1_q;
			if (accept && con_d == CON_ACK) begin
				cfg_q     <= PROTO_CFG_I;
				ack_sr_q  <= {PROTO_CFG_I, PROTO_POS_I, PROTO_ADDR_I};
				ack_cnt_q <= '0;
			end else if (con_q == CON_ACK) begin
				ack_sr_q  <= {1'b0, ack_sr_q[ACK_W-1:1]};
				ack_cnt_q <= ack_cnt_q + 5'h01;
			end
			if (ack_s2_q == req_q && stat_live != stat_hold_q) begin
				stat_hold_q <= stat_live;
				req_q       <= ~req_q;
			end
			PRIMARY_TEST_DATA_OUT_O      <= pdo_d;
			PRIMARY_TEST_DATA_OUT_OE_O   <= pdo_oe_d;
			SECONDARY_TEST_DATA_OUT_O    <= sdo_d;
			SECONDARY_TEST_DATA_OUT_OE_O <= sdo_oe_d;
			SECONDARY_MODE_SELECT_O      <= sms_d;
		end
	end

	// Bus address decode
	wire aw_take  = S_AXI_AWVALID_I && S_AXI_AWREADY_O;
	wire w_take   = S_AXI_WVALID_I && S_AXI_WREADY_O;
	wire ar_take  = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
	wire wr_go    = !S_AXI_AWREADY_O && !S_AXI_WREADY_O && !S_AXI_BVALID_O;
	wire wr_ctrl  = (awaddr_q == CTRL_OFFSET);
	wire rd_ctrl  = (S_AXI_ARADDR_I == CTRL_OFFSET);
	wire rd_stat  = (S_AXI_ARADDR_I == STATUS_OFFSET);
	wire [31:0] rd_data = rd_ctrl ? {31'h0, rx_en_q} :
		rd_stat ? {{(32 - STAT_W){1'b0}}, stat_sys_q} : 32'h0;

	// System domain registers and bus slave
	always_ff @(posedge SYS_CLK_I) begin
		if (SRST_I) begin
			rx_en_q         <= CTRL_RX_EN_RESET;
			req_s1_q        <= 1'b0;
			req_s2_q        <= 1'b0;
			ack_q           <= 1'b0;
			stat_sys_q      <= '0;
			awaddr_q        <= '0;
			wdata_q         <= '0;
			wstrb_q         <= '0;
			S_AXI_AWREADY_O <= 1'b1;
			S_AXI_WREADY_O  <= 1'b1;
			S_AXI_BVALID_O  <= 1'b0;
			S_AXI_BRESP_O   <= RESP_OKAY;
			S_AXI_ARREADY_O <= 1'b1;
			S_AXI_RVALID_O  <= 1'b0;
			S_AXI_RDATA_O   <= '0;
			S_AXI_RRESP_O   <= RESP_OKAY;
		end else begin
			req_s1_q <= req_q;
			req_s2_q <= req_s1_q;
			if (req_s2_q != ack_q) begin
				stat_sys_q <= stat_hold_q;
				ack_q      <= req_s2_q;
			end
			if (aw_take) begin
				awaddr_q        <= S_AXI_AWADDR_I;
				S_AXI_AWREADY_O <= 1'b0;
			end
			if (w_take) begin
				wdata_q        <= S_AXI_WDATA_I;
				wstrb_q        <= S_AXI_WSTRB_I;
				S_AXI_WREADY_O <= 1'b0;
			end
			if (wr_go) begin
				if (wr_ctrl && wstrb_q[0]) begin
					rx_en_q <= wdata_q[CTRL_RX_EN_BIT];
				end
				S_AXI_BRESP_O  <= wr_ctrl ? RESP_OKAY : RESP_SLVERR;
				S_AXI_BVALID_O <= 1'b1;
			end
			if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
				S_AXI_BVALID_O  <= 1'b0;
				S_AXI_AWREADY_O <= 1'b1;
				S_AXI_WREADY_O  <= 1'b1;
			end
			if (ar_take) begin
				S_AXI_ARREADY_O <= 1'b0;
				S_AXI_RVALID_O  <= 1'b1;
				S_AXI_RDATA_O   <= rd_data;
				S_AXI_RRESP_O   <= (rd_ctrl || rd_stat) ? RESP_OKAY : RESP_SLVERR;
			end
			if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
				S_AXI_RVALID_O  <= 1'b0;
				S_AXI_ARREADY_O <= 1'b1;
			end
		end
	end

	// Checks on the link domain
	a_ignore_unstable: assert property (PROTO_VALID_I && !stable_st && con_q != CON_ACK
		|=> $stable(con_q)) else $error("Protocol taken in an unstable state");
	a_reset_addr: assert property (accept && is_rsa |=> con_q == CON_RESET ##1
		(SECONDARY_MODE_SELECT_O == 3'h7 && !PRIMARY_TEST_DATA_OUT_OE_O
		&& SECONDARY_TEST_DATA_OUT_OE_O == 3'h0))
		else $error("Reset address did not reset the ports");
	a_drop_hold: assert property (accept && is_dsa ##1 con_q == CON_OFF |=>
		$stable(SECONDARY_MODE_SELECT_O) && !PRIMARY_TEST_DATA_OUT_OE_O)
		else $error("Drop-all address did not hold the ports");
	a_sync_pause: assert property (accept && is_tsa && pause_st |=> con_q == CON_MULTI)
		else $error("Sync broadcast not taken in a pause state");
	a_sync_idle: assert property (accept && is_tsa && !pause_st |=> con_q == CON_OFF)
		else $error("Sync broadcast recognized outside pause");
	a_mismatch_off: assert property (accept && !is_match && !is_rsa && !is_tsa && !is_dsa
		|=> con_q == CON_OFF ##1 !PRIMARY_TEST_DATA_OUT_OE_O)
		else $error("Mismatch did not turn the device off");
	a_match_ack: assert property (accept && is_match && !is_rsa && !is_tsa && !is_dsa
		|=> con_q == CON_ACK ##1 PRIMARY_TEST_DATA_OUT_OE_O)
		else $error("Match did not start an acknowledge");
	a_ack_then_on: assert property ($rose(con_q == CON_ACK) |-> (con_q == CON_ACK) [*8]
		##1 (con_q == CON_ACK) [*8] ##1 con_q == CON_ON)
		else $error("Acknowledge length wrong before ON");
	a_tap_walk: assert property (tap_q == TAP_PAUDR && PRIMARY_MODE_SELECT_I ##1
		!PRIMARY_MODE_SELECT_I |=> tap_q == TAP_SHDR)
		else $error("State monitor walk wrong");

endmodule : scan_link_connect_control

// [rtl/scan_link_pkg.sv]
// Package of constants and types for the scan linker connect control
package scan_link_pkg;

	// Received protocol field widths
	localparam int ADDR_W = 10;
	localparam int POS_W  = 3;
	localparam int CFG_W  = 3;
	localparam int ACK_W  = ADDR_W + POS_W + CFG_W;
	localparam int NPORT  = 3;

	// Dedicated global addresses
	localparam logic [ADDR_W-1:0] RESET_ALL_ADDRESS     = 10'h000;
	localparam logic [ADDR_W-1:0] DROP_ALL_ADDRESS      = 10'h3fe;
	localparam logic [ADDR_W-1:0] SYNC_BROADCAST_ADDRESS = 10'h3ff;

	// Acknowledge length as a bit counter limit
	localparam logic [4:0] ACK_LAST = 5'h0f;

	// Register map and fields
	localparam logic [31:0] CTRL_OFFSET   = 32'h0000_0000;
	localparam logic [31:0] STATUS_OFFSET = 32'h0000_0004;
	localparam int          CTRL_RX_EN_BIT = 0;
	localparam logic        CTRL_RX_EN_RESET = 1'b1;
	localparam int          STAT_W       = 24;
	localparam int          STAT_TAP_LSB = 0;
	localparam int          STAT_CON_LSB = 16;
	localparam int          STAT_CFG_LSB = 21;

	// Bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Primary port state monitor, one-hot
	typedef enum logic [15:0] {
		TAP_TLR   = 16'h0001,
		TAP_RTI   = 16'h0002,
		TAP_SELDR = 16'h0004,
		TAP_CAPDR = 16'h0008,
		TAP_SHDR  = 16'h0010,
		TAP_EX1DR = 16'h0020,
		TAP_PAUDR = 16'h0040,
		TAP_EX2DR = 16'h0080,
		TAP_UPDR  = 16'h0100,
		TAP_SELIR = 16'h0200,
		TAP_CAPIR = 16'h0400,
		TAP_SHIR  = 16'h0800,
		TAP_EX1IR = 16'h1000,
		TAP_PAUIR = 16'h2000,
		TAP_EX2IR = 16'h4000,
		TAP_UPIR  = 16'h8000
	} tap_state_t;

	// Connect status, one-hot
	typedef enum logic [4:0] {
		CON_OFF   = 5'h01,
		CON_ACK   = 5'h02,
		CON_ON    = 5'h04,
		CON_RESET = 5'h08,
		CON_MULTI = 5'h10
	} con_state_t;

endpackage : scan_link_pkg
